// [dv/dma_channel_ram_arbitration_properties.sv]
// dma_channel_ram_arbitration_properties: port checks on the dma block.
// assumes it is bound to the top module and sees its ports only.
module dma_channel_ram_arbitration_properties #(
  parameter int unsigned CNT_W = dma_pkg::CNT_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] paddr,
  input wire logic pslverr,
  input wire logic [dma_pkg::NUM_MASTERS-1:0] other_req,
  input wire logic [31:0] other_addr [dma_pkg::NUM_MASTERS],
  input wire logic [dma_pkg::NUM_MASTERS-1:0] master_grant,
  input wire logic ram_en,
  input wire logic ram_we,
  input wire logic [3:0] ram_be,
  input wire logic [31:0] ram_addr,
  input wire logic [7:0] rd_byte,
  input wire logic rd_valid,
  input wire logic rd_ready
);
  import dma_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // a slave spans two 4 kB sections, so compare above bit 12
  wire s01 = other_addr[0][31:13] == other_addr[1][31:13];
  wire s12 = other_addr[1][31:13] == other_addr[2][31:13];
  wire acc = psel && penable;
  a_cpu_first: assert property (other_req[0] |-> master_grant[0])
    else $error("cpu request not granted");
  a_rank_order: assert property (other_req[0] && other_req[1] && s01 |-> !master_grant[1])
    else $error("lower rank granted");
  a_section_pair: assert property (!other_req[0] && other_req[2] && other_req[1] && s12 |-> master_grant[1] && !master_grant[2])
    else $error("sections of one slave arbitrated apart");
  a_grant_cause: assert property (master_grant[3] |-> other_req[3])
    else $error("grant without request");
  a_ram_window: assert property (ram_en |-> ram_addr >= RAM_BASE && ram_addr < RAM_BASE + RAM_BYTES)
    else $error("access outside data ram");
  a_byte_lane: assert property (ram_en |-> (ram_we ? $onehot(ram_be) : ram_be == 4'h0))
    else $error("byte lane enables wrong for access");
  a_stall_held: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_byte))
    else $error("stalled byte changed or lost");
  a_hole_error: assert property (acc && paddr[11:0] == 12'h020 |-> pslverr)
    else $error("unmapped access not flagged");
  a_map_clean: assert property (acc && paddr[11:0] <= OFF_STATUS && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access flagged");
endmodule : dma_channel_ram_arbitration_properties

bind dma_channel_ram_arbitration dma_channel_ram_arbitration_properties #(.CNT_W(CNT_W))
  props_inst (.pclk, .presetn, .psel, .penable, .paddr, .pslverr, .other_req, .other_addr,
  .master_grant, .ram_en, .ram_we, .ram_be, .ram_addr, .rd_byte, .rd_valid, .rd_ready);

// [dv/dma_channel_ram_arbitration_test.sv]
// dma_channel_ram_arbitration_test: self-checking bench for the dma block.
// assumes the ram model answers the word port and the bench plays apb master.
module dma_channel_ram_arbitration_test;
  timeunit 1ns;
  timeprecision 1ps;
  import dma_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
  logic [31:0] paddr = 0, pwdata = 0, prdata, ram_addr, ram_wdata, ram_rdata, q;
  logic pready, pslverr, ram_en, ram_we, rd_valid, wr_ready, list_item_done;
  logic rd_ready = 0, wr_valid = 0;
  logic [7:0] rd_byte, wr_byte = 0;
  logic [3:0] ram_be;
  logic [NUM_MASTERS-1:0] other_req = 0, master_grant;
  logic [31:0] other_addr [NUM_MASTERS] = '{default: RAM_BASE};
  int miscompares = 0, total_checks = 0, cyc = 0, items = 0;
  dma_channel_ram_arbitration dma_channel_ram_arbitration_inst (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .other_req, .other_addr,
    .master_grant, .ram_en, .ram_we, .ram_be, .ram_addr, .ram_wdata, .ram_rdata, .rd_byte,
    .rd_valid, .rd_ready, .wr_byte, .wr_valid, .wr_ready, .list_item_done);
  dma_ram_model dma_ram_model_inst (.pclk, .ram_en, .ram_we, .ram_be, .ram_addr, .ram_wdata,
    .ram_rdata);
  initial forever #5 pclk = ~pclk;
  // the run needs a few hundred cycles; a hang ends here
  always @(posedge pclk) begin
    cyc++;
    if (list_item_done === 1'b1) items++;
    if (cyc == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  function automatic logic [7:0] pat(input logic [31:0] a);
    return a[7:0] ^ 8'h5a;
  endfunction : pat
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one transfer; request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {20'h0, a};
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // one write-stream byte, held until the design takes it
  task automatic push_byte(input logic [7:0] b);
    wr_byte <= b;
    wr_valid <= 1'b1;
    do @(posedge pclk); while (wr_ready !== 1'b1);
  endtask : push_byte
  // consumer side of the read stream
  task automatic take(input logic [31:0] a, input int n);
    rd_ready <= 1'b1;
    for (int i = 0; i < n; i++) begin
      do @(posedge pclk); while (rd_valid !== 1'b1);
      chk(rd_byte, pat(a + i));
    end
    rd_ready <= 1'b0;
  endtask : take
  task automatic t_regs();
    apb(0, OFF_RD_AMT, 0); chk(q, 0);
    apb(0, 12'h020, 0); chk(e, 1);
    apb(1, OFF_RD_MAX, 5); apb(0, OFF_RD_MAX, 0); chk(q, 5);
    $display("regs test done");
  endtask : t_regs
  task automatic t_read();
    apb(1, OFF_RD_PTR, RAM_BASE + 1);
    apb(1, OFF_CTRL, 1 << CTRL_RD_START);
    repeat (10) @(posedge pclk); // consumer stalls; nothing may be lost
    take(RAM_BASE + 1, 5);
    apb(0, OFF_RD_AMT, 0); chk(q, 5);
    apb(0, OFF_STATUS, 0); chk(q[ST_RD_DONE], 1);
    chk(rd_valid, 0);
    $display("read test done");
  endtask : t_read
  task automatic t_write();
    apb(1, OFF_WR_PTR, RAM_BASE + 5);
    apb(1, OFF_WR_MAX, 6);
    apb(1, OFF_CTRL, 1 << CTRL_WR_START);
    other_req[0] <= 1'b1; // cpu holds the same slave meanwhile
    other_addr[0] <= RAM_BASE + 32'h0000_0100;
    push_byte(8'hc0);
    push_byte(8'hc1);
    wr_valid <= 1'b0;
    repeat (5) @(posedge pclk);
    chk(wr_ready, 0);
    chk(dma_ram_model_inst.mem[1][15:8], pat(5));
    other_req[0] <= 1'b0;
    push_byte(8'hc2);
    wr_valid <= 1'b0;
    repeat (3) @(posedge pclk);
    apb(1, OFF_CTRL, 1 << CTRL_WR_STOP);
    repeat (3) @(posedge pclk);
    apb(0, OFF_WR_AMT, 0); chk(q, 3);
    chk(dma_ram_model_inst.mem[1][31:8], 24'hc2_c1c0);
    chk(dma_ram_model_inst.mem[2][7:0], pat(8));
    $display("write test done");
  endtask : t_write
  // every pair of outside masters, same slave then different slaves
  task automatic t_prio();
    for (int i = 0; i < NUM_MASTERS; i++)
      for (int j = i + 1; j < NUM_MASTERS; j++)
        if (!(i inside {5, 6}) && !(j inside {5, 6})) begin
          other_req <= (12'h001 << i) | (12'h001 << j);
          other_addr[i] <= RAM_BASE;
          other_addr[j] <= RAM_BASE + 32'h0000_1000;
          @(posedge pclk) chk({master_grant[i], master_grant[j]}, 2'b10);
          other_addr[j] <= RAM_BASE + 32'h0000_2000;
          @(posedge pclk) chk({master_grant[i], master_grant[j]}, 2'b11);
        end
    other_req <= '0;
    $display("priority test done");
  endtask : t_prio
  task automatic t_flash();
    apb(1, OFF_RD_PTR, 32'h0000_1000);
    apb(1, OFF_CTRL, 1 << CTRL_RD_START);
    repeat (3) @(posedge pclk);
    apb(0, OFF_STATUS, 0); chk(q[ST_ERR], 1);
    chk(rd_valid, 0);
    $display("flash test done");
  endtask : t_flash
  task automatic t_list();
    apb(1, OFF_RD_PTR, RAM_BASE + 32'h0000_0010);
    apb(1, OFF_RD_MAX, 4);
    items = 0;
    apb(1, OFF_CTRL, (1 << CTRL_LIST) | (1 << CTRL_RD_START));
    take(RAM_BASE + 32'h0000_0010, 12);
    repeat (4) @(posedge pclk);
    chk(items, 3);
    $display("list test done");
  endtask : t_list
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_read();
    t_write();
    t_prio();
    t_flash();
    t_list();
    report_and_stop();
  end
endmodule : dma_channel_ram_arbitration_test

// [dv/dma_ram_model.sv]
// dma_ram_model: word-wide data ram slave at the block's ram port.
// assumes a same-cycle read answer and byte-lane writes on pclk.
module dma_ram_model (
  input wire logic pclk,
  input wire logic ram_en,
  input wire logic ram_we,
  input wire logic [3:0] ram_be,
  input wire logic [31:0] ram_addr,
  input wire logic [31:0] ram_wdata,
  output logic [31:0] ram_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [64];
  wire [5:0] idx = ram_addr[7:2];
  // byte k of the window holds k ^ 5a so that every byte is distinguishable
  initial for (int i = 0; i < 256; i++) mem[i/4][8*(i%4)+:8] = 8'(i) ^ 8'h5a;
  // not enabled means no answer: the inverse keeps a stale word from passing
  assign ram_rdata = ram_en ? mem[idx] : ~mem[idx];
  // only the lanes named by the enables change
  always @(posedge pclk)
    for (int k = 0; k < 4; k++)
      if (ram_en && ram_we && ram_be[k]) mem[idx][8*k+:8] <= ram_wdata[8*k+:8];
endmodule : dma_ram_model

// [rtl/dma_channel_ram_arbitration.sv]
// dma_channel_ram_arbitration: a read and a write byte channel into data ram,
// with per-slave fixed-priority arbitration against the other masters.
// assumes a ram port that answers a granted word access in the same cycle and an apb master.
module dma_channel_ram_arbitration #(
  parameter int unsigned CNT_W = dma_pkg::CNT_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [dma_pkg::NUM_MASTERS-1:0] other_req,
  input wire logic [31:0] other_addr [dma_pkg::NUM_MASTERS],
  output logic [dma_pkg::NUM_MASTERS-1:0] master_grant,
  output logic ram_en,
  output logic ram_we,
  output logic [3:0] ram_be,
  output logic [31:0] ram_addr,
  output logic [31:0] ram_wdata,
  input wire logic [31:0] ram_rdata,
  output logic [7:0] rd_byte,
  output logic rd_valid,
  input wire logic rd_ready,
  input wire logic [7:0] wr_byte,
  input wire logic wr_valid,
  output logic wr_ready,
  output logic list_item_done
);
  import dma_pkg::*;
  localparam int unsigned RD_IDX = M_UART;  // this block's read channel rank
  localparam int unsigned WR_IDX = M_SERIAL_ZERO;  // write channel rank, distinct slot
  // apb decode
  logic [31:0] rd_ptr_r, wr_ptr_r, rd_cur_r, wr_cur_r;
  logic [CNT_W-1:0] rd_max_r, wr_max_r, rd_amt_r, wr_amt_r, rd_left_r, wr_left_r;
  logic list_r, rd_done_r, wr_done_r, err_r;
  ch_state_t rd_st_r, wr_st_r;
  logic buf_in_ready;
  logic wb_valid;
  logic [7:0] wb_data;
  logic wb_in_ready;
  logic [1:0] wr_pend_r;
  wire acc = psel && penable;
  wire wr_acc = acc && pwrite;
  wire [11:0] off = paddr[11:0];
  wire hit_any = (paddr[31:12] == 20'h0_0000) && (off[1:0] == 2'b00) && (off <= OFF_STATUS);
  wire wr_ctrl = wr_acc && hit_any && (off == OFF_CTRL);
  wire rd_start = wr_ctrl && pwdata[CTRL_RD_START] && (rd_st_r == CH_IDLE);
  wire wr_start = wr_ctrl && pwdata[CTRL_WR_START] && (wr_st_r == CH_IDLE);
  wire wr_stop = wr_ctrl && pwdata[CTRL_WR_STOP];
  // pointer range check: a channel aimed outside data ram is refused, never issued
  wire rd_in_ram = (rd_ptr_r >= RAM_BASE) &&
                   (rd_ptr_r - RAM_BASE < RAM_BYTES);
  wire wr_in_ram = (wr_ptr_r >= RAM_BASE) && (wr_ptr_r - RAM_BASE < RAM_BYTES);
  assign pready = 1'b1;
  assign pslverr = acc && !hit_any;
  // read mux
  always_comb begin
    prdata = 32'h0000_0000;
    unique case (off)
      OFF_RD_PTR: prdata = rd_ptr_r;
      OFF_RD_MAX: prdata = {{(32-CNT_W){1'b0}}, rd_max_r};
      OFF_RD_AMT: prdata = {{(32-CNT_W){1'b0}}, rd_amt_r};
      OFF_WR_PTR: prdata = wr_ptr_r;
      OFF_WR_MAX: prdata = {{(32-CNT_W){1'b0}}, wr_max_r};
      OFF_WR_AMT: prdata = {{(32-CNT_W){1'b0}}, wr_amt_r};
      OFF_CTRL: prdata = {29'h0000_0000, list_r, 2'b00};
      OFF_STATUS: prdata = {27'h000_0000, err_r, wr_done_r, rd_done_r,
                            wr_st_r != CH_IDLE, rd_st_r != CH_IDLE};
      default: prdata = 32'h0000_0000;
    endcase
    if (!(acc && !pwrite && hit_any)) prdata = 32'h0000_0000;
  end
  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ptr_r <= 32'h0000_0000;
      wr_ptr_r <= 32'h0000_0000;
      rd_max_r <= '0;
      wr_max_r <= '0;
      list_r <= 1'b0;
    end else if (wr_acc && hit_any) begin
      if (off == OFF_RD_PTR) rd_ptr_r <= pwdata;  // any byte address
      if (off == OFF_RD_MAX) rd_max_r <= pwdata[CNT_W-1:0];  // trusted
      if (off == OFF_WR_PTR) wr_ptr_r <= pwdata;
      if (off == OFF_WR_MAX) wr_max_r <= pwdata[CNT_W-1:0];
      if (off == OFF_CTRL) list_r <= pwdata[CTRL_LIST];
    end
  end
  // arbitration: one grant per ram slave, lowest index wins
  logic [NUM_MASTERS-1:0] req_all;
  logic [31:0] addr_all [NUM_MASTERS];
  logic [NUM_MASTERS-1:0] is_ram;
  wire rd_want = (rd_st_r == CH_REQ) && buf_in_ready;
  wire wr_want = (wr_st_r == CH_REQ) && wb_valid;
  genvar gm;
  generate
    for (gm = 0; gm < NUM_MASTERS; gm++) begin : g_req
      // own channels take their slots, the rest come from outside
      assign req_all[gm] = (gm == RD_IDX) ? rd_want :
                           (gm == WR_IDX) ? wr_want : other_req[gm];
      assign addr_all[gm] = (gm == RD_IDX) ? rd_cur_r :
                            (gm == WR_IDX) ? wr_cur_r : other_addr[gm];
      assign is_ram[gm] = (addr_all[gm] >= RAM_BASE) &&
                          (addr_all[gm] - RAM_BASE < RAM_BYTES);
    end
  endgenerate
  // a master wins if no higher one contends for the same slave; non-ram only cpu
  always_comb begin
    master_grant = '0;
    for (int i = 0; i < NUM_MASTERS; i++) begin
      master_grant[i] = req_all[i] && (is_ram[i] || i == M_CPU);
      for (int j = 0; j < i; j++) begin
        if (req_all[j] && is_ram[j] && is_ram[i] &&
            addr_all[j][31:SLAVE_SHIFT] == addr_all[i][31:SLAVE_SHIFT])
          master_grant[i] = 1'b0;
      end
    end
  end
  wire rd_gnt = master_grant[RD_IDX];
  wire wr_gnt = master_grant[WR_IDX];
  // ram port: write channel wins the port when both granted to different slaves
  wire rd_go = rd_gnt && !wr_gnt;
  wire wr_go = wr_gnt;
  assign ram_en = rd_go || wr_go;
  assign ram_we = wr_go;
  assign ram_addr = {(wr_go ? wr_cur_r[31:2] : rd_cur_r[31:2]), 2'b00};
  assign ram_be = wr_go ? (4'h1 << wr_cur_r[1:0]) : 4'h0;  // byte lane
  assign ram_wdata = {4{wb_data}};
  wire [7:0] rd_pick = ram_rdata[{rd_cur_r[1:0], 3'b000} +: 8];
  // read channel: one byte per granted access until max count
  wire rd_last = rd_go && (rd_left_r == CNT_W'(1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_st_r <= CH_IDLE;
      rd_cur_r <= 32'h0000_0000;
      rd_left_r <= '0;
      rd_amt_r <= '0;
      rd_done_r <= 1'b0;
    end else if (rd_start) begin
      rd_st_r <= (rd_in_ram && rd_max_r != '0) ? CH_REQ : CH_DONE;
      rd_cur_r <= rd_ptr_r;
      rd_left_r <= rd_max_r;
      rd_amt_r <= '0;
      rd_done_r <= 1'b0;
    end else if (rd_st_r == CH_REQ && rd_go) begin
      rd_cur_r <= rd_cur_r + 32'h0000_0001;  // linear walk
      rd_amt_r <= rd_amt_r + CNT_W'(1);
      rd_left_r <= rd_last ? (list_r ? rd_max_r : '0) : rd_left_r - CNT_W'(1);
      if (rd_last && !list_r) rd_st_r <= CH_DONE;
    end else if (rd_st_r == CH_DONE) begin
      rd_st_r <= CH_IDLE;
      rd_done_r <= 1'b1;
    end
    // a lost grant leaves cur and left untouched
  end
  // list mode ends with the item in progress once a control write clears the list bit; pulse marks each full item read while the list bit is still set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) list_item_done <= 1'b0;
    else list_item_done <= rd_last && list_r;
  end
  dma_skid_buf #(.WIDTH(8)) u_rd_buf (
    .pclk(pclk), .presetn(presetn),
    .in_valid(rd_go && rd_st_r == CH_REQ), .in_ready(buf_in_ready), .in_data(rd_pick),
    .out_valid(rd_valid), .out_ready(rd_ready), .out_data(rd_byte), .flush(rd_start)
  );
  // write channel: peripheral bytes land through the buffer, at most max count
  dma_skid_buf #(.WIDTH(8)) u_wr_buf (
    .pclk(pclk), .presetn(presetn),
    .in_valid(wr_push), .in_ready(wb_in_ready), .in_data(wr_byte),
    .out_valid(wb_valid), .out_ready(wr_go), .out_data(wb_data), .flush(wr_start)
  );
  // room left = bytes still allowed minus bytes already buffered
  assign wr_ready = wb_in_ready && (wr_st_r == CH_REQ) && (wr_left_r > CNT_W'(wr_pend_r));
  wire wr_push = wr_valid && wr_ready;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wr_pend_r <= 2'd0;
    else if (wr_start) wr_pend_r <= 2'd0;
    else wr_pend_r <= wr_pend_r + {1'b0, wr_push} - {1'b0, wr_go};
  end
  // error flag follows the latest start of either channel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) err_r <= 1'b0;
    else if (rd_start || wr_start) err_r <= (rd_start && !rd_in_ram) ||
                                            (wr_start && !wr_in_ram);
  end
  wire wr_last = wr_go && (wr_left_r == CNT_W'(1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_st_r <= CH_IDLE;
      wr_cur_r <= 32'h0000_0000;
      wr_left_r <= '0;
      wr_amt_r <= '0;
      wr_done_r <= 1'b0;
    end else if (wr_start) begin
      wr_st_r <= (wr_in_ram && wr_max_r != '0) ? CH_REQ : CH_DONE;
      wr_cur_r <= wr_ptr_r;
      wr_left_r <= wr_max_r;  // never more than max count
      wr_amt_r <= '0;
      wr_done_r <= 1'b0;
    end else if (wr_st_r == CH_REQ && wr_go) begin
      wr_cur_r <= wr_cur_r + 32'h0000_0001;
      wr_amt_r <= wr_amt_r + CNT_W'(1);
      wr_left_r <= wr_left_r - CNT_W'(1);
      if (wr_last) wr_st_r <= CH_DONE;
    end else if (wr_st_r == CH_REQ && wr_stop && !wb_valid) begin
      wr_st_r <= CH_DONE;  // peripheral ended early, amount stays short
    end else if (wr_st_r == CH_DONE) begin
      wr_st_r <= CH_IDLE;
      wr_done_r <= 1'b1;
    end
  end
endmodule : dma_channel_ram_arbitration

// [rtl/dma_pkg.sv]
// dma_pkg: register map, field layout, master ranks and widths for the dma channel block.
// assumes one clock (pclk) and an apb slave port; shared by the top and its buffer.
package dma_pkg;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned CNT_W = 16;
  // register byte offsets (own layout, one aligned word each)
  localparam logic [11:0] OFF_RD_PTR = 12'h000;
  localparam logic [11:0] OFF_RD_MAX = 12'h004;
  localparam logic [11:0] OFF_RD_AMT = 12'h008;
  localparam logic [11:0] OFF_WR_PTR = 12'h00C;
  localparam logic [11:0] OFF_WR_MAX = 12'h010;
  localparam logic [11:0] OFF_WR_AMT = 12'h014;
  localparam logic [11:0] OFF_CTRL = 12'h018;
  localparam logic [11:0] OFF_STATUS = 12'h01C;
  // control fields
  localparam int unsigned CTRL_RD_START = 0;
  localparam int unsigned CTRL_WR_START = 1;
  localparam int unsigned CTRL_LIST = 2;
  localparam int unsigned CTRL_WR_STOP = 3;
  // status fields
  localparam int unsigned ST_RD_BUSY = 0;
  localparam int unsigned ST_WR_BUSY = 1;
  localparam int unsigned ST_RD_DONE = 2;
  localparam int unsigned ST_WR_DONE = 3;
  localparam int unsigned ST_ERR = 4;
  // data ram window: 4 kB sections, two per slave
  localparam logic [31:0] RAM_BASE = 32'h2000_0000;
  localparam int unsigned SECT_BYTES = 4096;
  localparam int unsigned SECTS_PER_SLAVE = 2;
  localparam int unsigned SLAVE_SHIFT = $clog2(SECT_BYTES * SECTS_PER_SLAVE);
  localparam int unsigned NUM_SLAVES = 8;
  localparam logic [31:0] RAM_BYTES = 32'h0001_0000;
  // masters, highest first
  typedef enum logic [3:0] {
    M_CPU = 4'h0, M_SERIAL_ONE = 4'h1, M_RADIO = 4'h2, M_CRYPTO = 4'h3,
    M_ADC = 4'h4, M_UART = 4'h5, M_SERIAL_ZERO = 4'h6, M_SERIAL_TWO = 4'h7,
    M_NFC = 4'h8, M_AUDIO = 4'h9, M_MIC = 4'hA, M_PWM = 4'hB
  } master_t;
  localparam int unsigned NUM_MASTERS = 12;
  typedef enum logic [1:0] {
    CH_IDLE = 2'b00, CH_REQ = 2'b01, CH_DONE = 2'b10
  } ch_state_t;
  localparam logic [1:0] BUF_DEPTH = 2'd2;
endpackage : dma_pkg

// [rtl/dma_skid_buf.sv]
// dma_skid_buf: two-entry valid/ready buffer in the byte path.
// assumes synchronous use on pclk; the drain side may stall at will.
module dma_skid_buf #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  input wire logic flush
);
  import dma_pkg::*;
  logic [WIDTH-1:0] mem_r [2];
  logic rd_r;
  logic wr_r;
  logic [1:0] cnt_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  // full and empty follow the count honestly, so a stalled drain fills it
  assign in_ready = (cnt_r != BUF_DEPTH);
  assign out_valid = (cnt_r != 2'd0);
  assign out_data = mem_r[rd_r];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 2'd0;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
    end else if (flush) begin
      cnt_r <= 2'd0;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
    end else begin
      if (push) wr_r <= ~wr_r;
      if (pop) rd_r <= ~rd_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
  // storage is plain flops; no reset needed on data
  always_ff @(posedge pclk) begin
    if (push) mem_r[wr_r] <= in_data;
  end
endmodule : dma_skid_buf
